// >>> verilog/camac_status_lam_interface.sv
// Dataway status registers, look-at-me logic and Q/X answers.
// Assumes event and count inputs come from logic on the same clock.
//
// How it works
// R01: Each command is recognised from function code and subaddress together.
// R02: Function zero reads a status register chosen by subaddress 0, 1 or 2.
// R03: Look-at-me is raised one microsecond after each event that arrives while no hold is running.
// R04: Look-at-me holds until cleared; reading register one or two clears it.
// R05: The clear look-at-me command clears the pending request.
// R06: Board reset clears the pending request.
// R07: The dataway look-at-me line follows the request only when enabled.
// R08: Board reset or the disable command masks the request.
// R09: The enable command unmasks the request.
// R10: Register three shows request in bit 0 and enable in bit 1.
// R11: Test look-at-me reports request AND enable.
// R12: Register one bits 15 to 12 hold the latched sample clock count.
// R13: Register one bit 11 always reads zero.
// R14: Register one bits 10 to 8 hold the latched fast clock count.
// R15: Register one low byte holds interval count bits 23 to 16.
// R16: Register two holds interval count bits 15 to 0.
// R17: Register three bit 4 shows first event seen; bits 7 to 5 zero.
// R18: Register three bits 3 and 2 show the high and low straps.
// R19: Reset command and initialise signal Z both reset the whole board.
// R20: Every recognised command answers with Q and X.
// R21: Fitted strap reads 0; strap pair selects the sample clock rate.
// R22: The interval counter stays disabled until the first event.
// R23: The controller reads interval data before the next event overwrites it.
// R24: Unrecognised commands give no Q, no X and change nothing.
// R25: Reading register three leaves request and mask unchanged.
`timescale 1ns/1ps
module camac_status_lam_interface
(
   // Clock and reset.
   input  wire logic                              clk_in,
   input  wire logic                              rst_b_in,
   // Dataway command pins.
   input  wire logic                              station_n_in,
   input  wire logic                              strobe_in,
   input  wire logic                              init_z_in,
   input  wire logic [dataway_pkg::FUNC_W-1:0]    func_in,
   input  wire logic [dataway_pkg::SUB_W-1:0]     sub_in,
   // Dataway answer pins.
   output logic      [dataway_pkg::DATA_W-1:0]    read_data_out,
   output logic                                   q_out,
   output logic                                   x_out,
   output logic                                   lam_out,
   // Frequency straps.
   input  wire logic                              freq_strap_high_in,
   input  wire logic                              freq_strap_low_in,
   // Counter side.
   input  wire logic                              event_in,
   input  wire logic [3:0]                        sample_count_in,
   input  wire logic [2:0]                        fast_count_in,
   input  wire logic [dataway_pkg::COUNT_W-1:0]   interval_count_in,
   output logic                                   interval_enable_out,
   output logic                                   board_reset_out,
   output logic      [1:0]                        freq_select_out
);
   import dataway_pkg::*;

   dataway_cmd_if cmd_if ();

   logic [PIN_W-1:0] pins;

   assign pins = {station_n_in, strobe_in, init_z_in, freq_strap_high_in,
                  freq_strap_low_in, func_in, sub_in};

   dataway_decoder u_decoder
   (
      .clk_in   (clk_in),
      .rst_b_in (rst_b_in),
      .pins_in  (pins),
      .cmd_if   (cmd_if.decoder)
   );

   // Look-at-me and mask state.
   logic                      lam_reg, lam_next;
   logic                      mask_en_reg, mask_en_next;
   logic                      first_reg, first_next;
   lam_state_t                state_reg, state_next;
   logic [DELAY_W-1:0]        delay_reg, delay_next;

   // Latched measurements.
   logic [DATA_W-1:0]         sr1_reg, sr1_next;
   logic [DATA_W-1:0]         sr2_reg, sr2_next;

   // Dataway answers and counter-side outputs.
   logic [DATA_W-1:0]         rdata_reg, rdata_next;
   logic                      q_reg, q_next;
   logic                      x_reg, x_next;
   logic                      lam_line_reg, lam_line_next;
   logic                      brst_reg, brst_next;
   logic                      ien_reg, ien_next;
   logic [1:0]                freq_reg, freq_next;

   logic                      board_reset;
   logic                      latch_now;
   logic                      read_clear;
   logic [7:0]                sr3;

   always_comb
   begin
      board_reset = (cmd_if.cmd_valid && cmd_if.cmd == CMD_RESET)
                    || cmd_if.init_active;                       // [R19]
      latch_now   = (state_reg == ST_HOLD) && (delay_reg == '0);
      read_clear  = cmd_if.cmd_valid
                    && (cmd_if.cmd == CMD_READ1
                        || cmd_if.cmd == CMD_READ2);             // [R04]
      sr3 = {3'h0, first_reg, cmd_if.strap_high, cmd_if.strap_low,
             mask_en_reg, lam_reg}; // [R10] [R17] [R18]

      state_next   = state_reg;
      delay_next   = delay_reg;
      first_next   = first_reg;
      lam_next     = lam_reg;
      mask_en_next = mask_en_reg;
      sr1_next     = sr1_reg;
      sr2_next     = sr2_reg;

      // Event timing: hold the interval counter for one microsecond.
      unique case (state_reg)
         ST_IDLE:
         begin
            if (event_in)
            begin
               state_next = ST_HOLD;
               delay_next = DELAY_W'(LAM_DELAY_CYCLES - 1);      // [R03]
               first_next = 1'b1;                                // [R22]
            end
         end
         ST_HOLD:
         begin
            if (delay_reg == '0)
            begin
               state_next = ST_IDLE;
            end
            else
            begin
               delay_next = delay_reg - DELAY_W'(1);
            end
         end
      endcase

      // Mask commands.
      if (cmd_if.cmd_valid && cmd_if.cmd == CMD_DIS_LAM)
      begin
         mask_en_next = 1'b0;                                    // [R08]
      end
      if (cmd_if.cmd_valid && cmd_if.cmd == CMD_ENA_LAM)
      begin
         mask_en_next = 1'b1;                                    // [R09]
      end

      // Clears first, so a simultaneous latch still raises the request.
      if (read_clear || (cmd_if.cmd_valid && cmd_if.cmd == CMD_CLR_LAM))
      begin
         lam_next = 1'b0;                                        // [R04] [R05]
      end
      if (latch_now)
      begin
         lam_next = 1'b1;                                        // [R03]
         sr1_next = {sample_count_in, 1'b0, fast_count_in, // [R12] [R13] [R14]
                     interval_count_in[23:16]}; // [R15] [R23]
         sr2_next = interval_count_in[15:0];                     // [R16]
      end

      if (board_reset)
      begin
         state_next   = ST_IDLE;
         delay_next   = '0;
         first_next   = 1'b0;
         lam_next     = 1'b0;                                    // [R06]
         mask_en_next = MASK_RESET;                              // [R08]
         sr1_next     = DATA_RESET;
         sr2_next     = DATA_RESET;
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         state_reg   <= ST_IDLE;
         delay_reg   <= '0;
         first_reg   <= 1'b0;
         lam_reg     <= 1'b0;
         mask_en_reg <= MASK_RESET;
         sr1_reg     <= DATA_RESET;
         sr2_reg     <= DATA_RESET;
      end
      else
      begin
         state_reg   <= state_next;
         delay_reg   <= delay_next;
         first_reg   <= first_next;
         lam_reg     <= lam_next;
         mask_en_reg <= mask_en_next;
         sr1_reg     <= sr1_next;
         sr2_reg     <= sr2_next;
      end
   end

   // Answers to the dataway, held while the strobe stays active.
   always_comb
   begin
      rdata_next = rdata_reg;
      q_next     = q_reg;
      x_next     = x_reg;
      if (!cmd_if.strobe_active)
      begin
         rdata_next = DATA_RESET;
         q_next     = 1'b0;
         x_next     = 1'b0;
      end
      if (cmd_if.cmd_valid)
      begin
         q_next = 1'b1;                                          // [R20]
         x_next = 1'b1;                                          // [R20]
         unique case (cmd_if.cmd)
            CMD_READ1: rdata_next = sr1_reg;                     // [R02]
            CMD_READ2: rdata_next = sr2_reg;                     // [R02]
            CMD_READ3: rdata_next = {8'h00, sr3};                // [R02] [R25]
            CMD_TEST:  rdata_next = {15'h0000,
                                     lam_reg & mask_en_reg};     // [R11]
            default:   rdata_next = DATA_RESET;
         endcase
      end
      lam_line_next = lam_next & mask_en_next;                   // [R07]
      brst_next     = board_reset;                               // [R19]
      ien_next      = first_next && (state_next == ST_IDLE);     // [R22]
      freq_next     = {cmd_if.strap_high, cmd_if.strap_low};     // [R21]
   end

   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         rdata_reg    <= DATA_RESET;
         q_reg        <= 1'b0;
         x_reg        <= 1'b0;
         lam_line_reg <= 1'b0;
         brst_reg     <= 1'b0;
         ien_reg      <= 1'b0;
         freq_reg     <= 2'h0;
      end
      else
      begin
         rdata_reg    <= rdata_next;
         q_reg        <= q_next;
         x_reg        <= x_next;
         lam_line_reg <= lam_line_next;
         brst_reg     <= brst_next;
         ien_reg      <= ien_next;
         freq_reg     <= freq_next;
      end
   end

   assign read_data_out       = rdata_reg;
   assign q_out               = q_reg;
   assign x_out               = x_reg;
   assign lam_out             = lam_line_reg;
   assign board_reset_out     = brst_reg;
   assign interval_enable_out = ien_reg;
   assign freq_select_out     = freq_reg;

endmodule // camac_status_lam_interface

// >>> include/dataway_pkg.sv
// Constants, command codes and states shared by the dataway status block.
// Assumes a 20 MHz system clock and dataway pins that are asynchronous.
package dataway_pkg;

   // Clock and look-at-me delay.
   localparam int CLK_PERIOD_NS    = 50;
   localparam int LAM_DELAY_NS     = 1000;
   localparam int LAM_DELAY_CYCLES =
      (LAM_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DELAY_W          = 5;

   // Dataway field widths.
   localparam int FUNC_W  = 5;
   localparam int SUB_W   = 4;
   localparam int DATA_W  = 16;
   localparam int COUNT_W = 24;

   // Function codes and subaddresses of the supported commands.
   localparam logic [4:0] FUNC_READ     = 5'h00;
   localparam logic [4:0] FUNC_TEST_LAM = 5'h08;
   localparam logic [4:0] FUNC_RESET    = 5'h09;
   localparam logic [4:0] FUNC_CLR_LAM  = 5'h0a;
   localparam logic [4:0] FUNC_DIS_LAM  = 5'h18;
   localparam logic [4:0] FUNC_ENA_LAM  = 5'h1a;
   localparam logic [3:0] SUB_REG_ONE   = 4'h0;
   localparam logic [3:0] SUB_REG_TWO   = 4'h1;
   localparam logic [3:0] SUB_REG_THREE = 4'h2;
   localparam logic [3:0] SUB_CONTROL   = 4'h0;
   localparam logic [3:0] SUB_BOARD     = 4'hf;

   // Positions in the synchronised pin vector.
   localparam int PIN_SUB    = 0;
   localparam int PIN_FUNC   = 4;
   localparam int PIN_STRAPL = 9;
   localparam int PIN_STRAPH = 10;
   localparam int PIN_INIT   = 11;
   localparam int PIN_STROBE = 12;
   localparam int PIN_STN    = 13;
   localparam int PIN_W      = 14;

   // Field positions in the first status register.
   localparam int SR1_SAMPLE_LSB   = 12;
   localparam int SR1_FAST_LSB     = 8;
   localparam int SR1_INTERVAL_LSB = 0;

   // Values after reset.
   localparam logic [15:0] DATA_RESET = 16'h0000;
   localparam logic        MASK_RESET = 1'b0;

   typedef enum logic [3:0] {
      CMD_NONE    = 4'h0,
      CMD_READ1   = 4'h1,
      CMD_READ2   = 4'h2,
      CMD_READ3   = 4'h3,
      CMD_TEST    = 4'h4,
      CMD_RESET   = 4'h5,
      CMD_CLR_LAM = 4'h6,
      CMD_DIS_LAM = 4'h7,
      CMD_ENA_LAM = 4'h8
   } cmd_t;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_HOLD = 1'b1
   } lam_state_t;

endpackage

// >>> include/dataway_cmd_if.sv
// Decoded dataway commands passed from the pin decoder to the core.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface dataway_cmd_if;
   import dataway_pkg::*;
   logic cmd_valid;
   cmd_t cmd;
   logic strobe_active;
   logic init_active;
   logic strap_high;
   logic strap_low;

   modport decoder (
      output cmd_valid,
      output cmd,
      output strobe_active,
      output init_active,
      output strap_high,
      output strap_low
   );

   modport core (
      input cmd_valid,
      input cmd,
      input strobe_active,
      input init_active,
      input strap_high,
      input strap_low
   );
endinterface

// >>> verilog/dataway_decoder.sv
// Synchronises the dataway pins and decodes commands into one-cycle pulses.
// Assumes function and subaddress settle before the strobe rises.
`timescale 1ns/1ps
module dataway_decoder
(
   // Clock and reset.
   input  wire logic                      clk_in,
   input  wire logic                      rst_b_in,
   // Raw pins.
   input  wire logic [dataway_pkg::PIN_W-1:0] pins_in,
   // Decoded commands.
   dataway_cmd_if.decoder                 cmd_if
);
   import dataway_pkg::*;

   logic [PIN_W-1:0] s1_reg, s2_reg, s3_reg, filt_reg, filt_next;
   logic             strobe_prev_reg, strobe_now;
   logic             valid_reg, valid_next;
   cmd_t             cmd_reg, cmd_next;

   function automatic cmd_t decode_cmd(input logic [FUNC_W-1:0] f,
                                       input logic [SUB_W-1:0]  a);
      cmd_t c;
      c = CMD_NONE;
      if (f == FUNC_READ && a == SUB_REG_ONE)       c = CMD_READ1;
      if (f == FUNC_READ && a == SUB_REG_TWO)       c = CMD_READ2;
      if (f == FUNC_READ && a == SUB_REG_THREE)     c = CMD_READ3;
      if (f == FUNC_TEST_LAM && a == SUB_BOARD)     c = CMD_TEST;
      if (f == FUNC_RESET && a == SUB_BOARD)        c = CMD_RESET;
      if (f == FUNC_CLR_LAM && a == SUB_CONTROL)    c = CMD_CLR_LAM;
      if (f == FUNC_DIS_LAM && a == SUB_CONTROL)    c = CMD_DIS_LAM;
      if (f == FUNC_ENA_LAM && a == SUB_CONTROL)    c = CMD_ENA_LAM;
      return c;
   endfunction

   always_comb
   begin
      for (int i = 0; i < PIN_W; i++)
      begin
         filt_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : filt_reg[i];
      end
      strobe_now = filt_reg[PIN_STROBE] & filt_reg[PIN_STN];
      valid_next = 1'b0;
      cmd_next   = CMD_NONE;
      if (strobe_now && !strobe_prev_reg)
      begin
         cmd_next   = decode_cmd(filt_reg[PIN_FUNC +: FUNC_W],
                                 filt_reg[PIN_SUB +: SUB_W]);  // [R01]
         valid_next = (cmd_next != CMD_NONE);                   // [R24]
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         s1_reg          <= '0;
         s2_reg          <= '0;
         s3_reg          <= '0;
         filt_reg        <= '0;
         strobe_prev_reg <= 1'b0;
         valid_reg       <= 1'b0;
         cmd_reg         <= CMD_NONE;
      end
      else
      begin
         s1_reg          <= pins_in;
         s2_reg          <= s1_reg;
         s3_reg          <= s2_reg;
         filt_reg        <= filt_next;
         strobe_prev_reg <= strobe_now;
         valid_reg       <= valid_next;
         cmd_reg         <= cmd_next;
      end
   end

   assign cmd_if.cmd_valid     = valid_reg;
   assign cmd_if.cmd           = cmd_reg;
   assign cmd_if.strobe_active = strobe_prev_reg;
   assign cmd_if.init_active   = filt_reg[PIN_INIT];
   assign cmd_if.strap_high    = filt_reg[PIN_STRAPH];
   assign cmd_if.strap_low     = filt_reg[PIN_STRAPL];

endmodule // dataway_decoder

// >>> verif/camac_status_lam_interface_properties.sv
// Checker of the dataway status block, watching its top-level ports only.
// Assumes one 20 MHz clock domain and the active-low asynchronous reset.
`timescale 1ns/1ps
module camac_status_lam_interface_checker
(
   // Clock and reset.
   input  wire logic        clk_in,
   input  wire logic        rst_b_in,
   // Dataway pins.
   input  wire logic        station_n_in,
   input  wire logic        strobe_in,
   input  wire logic        init_z_in,
   input  wire logic [4:0]  func_in,
   input  wire logic [3:0]  sub_in,
   input  wire logic [15:0] read_data_out,
   input  wire logic        q_out,
   input  wire logic        x_out,
   input  wire logic        lam_out,
   // Straps and counter side.
   input  wire logic        freq_strap_high_in,
   input  wire logic        freq_strap_low_in,
   input  wire logic        event_in,
   input  wire logic        interval_enable_out,
   input  wire logic        board_reset_out,
   input  wire logic [1:0]  freq_select_out
);
   import dataway_pkg::*;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);

   function automatic logic known(logic [4:0] f, logic [3:0] a);
      return (f == FUNC_READ && a <= SUB_REG_THREE) ||
         ({f, a} == {FUNC_TEST_LAM, SUB_BOARD}) ||
         ({f, a} == {FUNC_RESET, SUB_BOARD}) ||
         ({f, a} == {FUNC_CLR_LAM, SUB_CONTROL}) ||
         ({f, a} == {FUNC_DIS_LAM, SUB_CONTROL}) ||
         ({f, a} == {FUNC_ENA_LAM, SUB_CONTROL});
   endfunction

   property p_qx_together;
      q_out == x_out;
   endproperty
   a_qx_together: assert property (p_qx_together)
      else $error("q and x differ");

   property p_answer_needs_strobe;
      $rose(x_out) |-> $past(strobe_in, 4) && $past(station_n_in, 4);
   endproperty
   a_answer_needs_strobe: assert property (p_answer_needs_strobe)
      else $error("answer without a strobe");

   property p_refused;
      $rose(strobe_in) && station_n_in && !known(func_in, sub_in)
         |-> ##4 !x_out [*4];
   endproperty
   a_refused: assert property (p_refused)
      else $error("unknown command answered");

   property p_idle_data;
      !x_out |-> read_data_out == 16'h0000;
   endproperty
   a_idle_data: assert property (p_idle_data)
      else $error("read data without an answer");

   property p_lam_rise;
      $rose(lam_out) |-> $past(event_in, 21) || strobe_in || $past(strobe_in);
   endproperty
   a_lam_rise: assert property (p_lam_rise)
      else $error("look-at-me rose without cause");

   property p_event_hold;
      event_in && interval_enable_out |=> !interval_enable_out [*8];
   endproperty
   a_event_hold: assert property (p_event_hold)
      else $error("interval counter not held after event");

   property p_hold_length;
      $fell(interval_enable_out) && $past(event_in)
         |-> ##20 interval_enable_out;
   endproperty
   a_hold_length: assert property (p_hold_length)
      else $error("interval hold has wrong length");

   property p_reset_masks;
      board_reset_out |-> ##2 !lam_out;
   endproperty
   a_reset_masks: assert property (p_reset_masks)
      else $error("look-at-me after board reset");

   property p_init_resets;
      init_z_in [*8] |-> board_reset_out;
   endproperty
   a_init_resets: assert property (p_init_resets)
      else $error("initialise did not reset board");

   property p_straps;
      $stable({freq_strap_high_in, freq_strap_low_in}) [*8]
         |-> freq_select_out == {freq_strap_high_in, freq_strap_low_in};
   endproperty
   a_straps: assert property (p_straps)
      else $error("frequency select differs from straps");

   c_lam: cover property ($rose(lam_out));
   c_refused: cover property ($rose(strobe_in) && !known(func_in, sub_in));
   c_init: cover property (init_z_in [*8]);
endmodule // camac_status_lam_interface_checker

bind camac_status_lam_interface camac_status_lam_interface_checker i_checker
(
   .clk_in(clk_in), .rst_b_in(rst_b_in), .station_n_in(station_n_in),
   .strobe_in(strobe_in), .init_z_in(init_z_in), .func_in(func_in),
   .sub_in(sub_in), .read_data_out(read_data_out), .q_out(q_out),
   .x_out(x_out), .lam_out(lam_out),
   .freq_strap_high_in(freq_strap_high_in),
   .freq_strap_low_in(freq_strap_low_in), .event_in(event_in),
   .interval_enable_out(interval_enable_out),
   .board_reset_out(board_reset_out), .freq_select_out(freq_select_out)
);

// >>> verif/dataway_controller_model.sv
// Crate controller model that issues dataway commands and initialise.
// Assumes the block answers within eight edges of the strobe rising.
`timescale 1ns/1ps
module dataway_controller_model
(
   // Clock.
   input  wire logic        clk_in,
   // Answers from the block.
   input  wire logic        q_in,
   input  wire logic        x_in,
   input  wire logic [15:0] data_in,
   // Dataway command pins.
   output logic             station_n_out,
   output logic             strobe_out,
   output logic             init_z_out,
   output logic [4:0]       func_out,
   output logic [3:0]       sub_out
);
   initial
   begin
      station_n_out = 1'b0;
      strobe_out    = 1'b0;
      init_z_out    = 1'b0;
      func_out      = 5'h00;
      sub_out       = 4'h0;
   end

   // Function and subaddress settle before the strobe and change after.
   task automatic command(input logic [4:0] f, input logic [3:0] a,
      output logic [15:0] d, output logic q, output logic x,
      output logic gone);
      int n;
      @(posedge clk_in);
      func_out <= f;
      sub_out  <= a;
      repeat (5) @(posedge clk_in);
      strobe_out    <= 1'b1;
      station_n_out <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk_in);
         n++;
      end
      while (x_in !== 1'b1 && n < 8);
      d = data_in;
      q = q_in;
      x = x_in;
      strobe_out    <= 1'b0;
      station_n_out <= 1'b0;
      n = 0;
      do
      begin
         @(posedge clk_in);
         n++;
      end
      while (x_in !== 1'b0 && n < 12);
      gone = (x_in === 1'b0);
      func_out <= ~f;
      sub_out  <= ~a;
      repeat (3) @(posedge clk_in);
   endtask

   task automatic init_pulse();
      @(posedge clk_in);
      init_z_out <= 1'b1;
      repeat (10) @(posedge clk_in);
      init_z_out <= 1'b0;
      repeat (8) @(posedge clk_in);
   endtask
endmodule // dataway_controller_model

// >>> verif/test_camac_status_lam_interface.sv
// Self-checking testbench of the dataway status block.
// Assumes the controller model and the bound checker are compiled first.
`timescale 1ns/1ps
module test_camac_status_lam_interface;
   import dataway_pkg::*;

   localparam logic [8:0] BAD [8] = '{9'h003, 9'h080, 9'h090, 9'h0af,
      9'h181, 9'h1af, 9'h010, 9'h00f};

   logic        clk_in = 1'b0;
   logic        rst_b_in = 1'b0;
   logic        station_n_in, strobe_in, init_z_in;
   logic [4:0]  func_in;
   logic [3:0]  sub_in;
   logic [15:0] read_data_out;
   logic        q_out, x_out, lam_out;
   logic        freq_strap_high_in = 1'b1;
   logic        freq_strap_low_in = 1'b0;
   logic        event_in = 1'b0;
   logic [3:0]  sample_count_in = 4'h0;
   logic [2:0]  fast_count_in = 3'h0;
   logic [23:0] interval_count_in = 24'h000000;
   logic        interval_enable_out, board_reset_out;
   logic [1:0]  freq_select_out;
   int          errors = 0;
   int          check_count = 0;

   always #25 clk_in = ~clk_in;

   camac_status_lam_interface i_camac_status_lam_interface (
      .clk_in(clk_in), .rst_b_in(rst_b_in), .station_n_in(station_n_in),
      .strobe_in(strobe_in), .init_z_in(init_z_in), .func_in(func_in),
      .sub_in(sub_in), .read_data_out(read_data_out), .q_out(q_out),
      .x_out(x_out), .lam_out(lam_out),
      .freq_strap_high_in(freq_strap_high_in),
      .freq_strap_low_in(freq_strap_low_in), .event_in(event_in),
      .sample_count_in(sample_count_in), .fast_count_in(fast_count_in),
      .interval_count_in(interval_count_in),
      .interval_enable_out(interval_enable_out),
      .board_reset_out(board_reset_out), .freq_select_out(freq_select_out));

   dataway_controller_model i_dataway_controller_model (
      .clk_in(clk_in), .q_in(q_out), .x_in(x_out), .data_in(read_data_out),
      .station_n_out(station_n_in), .strobe_out(strobe_in),
      .init_z_out(init_z_in), .func_out(func_in), .sub_out(sub_in));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up();
      if (errors == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   function automatic logic [15:0] r3(logic f, logic h, logic l, logic e,
      logic r);
      return {11'h000, f, h, l, e, r};
   endfunction

   task automatic run(input logic [4:0] f, input logic [3:0] a,
      input logic ok, output logic [15:0] d);
      logic q, x, gone;
      i_dataway_controller_model.command(f, a, d, q, x, gone);
      check({14'h0, q, x}, {14'h0, ok, ok});
      check(16'(gone), 16'h0001);
   endtask

   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      logic [15:0] d;
      run(FUNC_READ, a, 1'b1, d);
      check(d, exp);
   endtask

   task automatic ctl(input logic [4:0] f, input logic [3:0] a,
      input logic exp_lam);
      logic [15:0] d;
      run(f, a, 1'b1, d);
      repeat (2) @(posedge clk_in);
      check(16'(lam_out), 16'(exp_lam));
   endtask

   task automatic fire(input logic [3:0] s, input logic [2:0] fc,
      input logic [23:0] iv);
      @(posedge clk_in);
      sample_count_in   <= s;
      fast_count_in     <= fc;
      interval_count_in <= iv;
      event_in          <= 1'b1;
      @(posedge clk_in);
      event_in <= 1'b0;
      repeat (23) @(posedge clk_in);
   endtask

   task automatic t_idle();
      check(16'(interval_enable_out), 16'h0000);
      rd(SUB_REG_THREE, r3(0, 1, 0, 0, 0));
   endtask

   task automatic t_masked_event();
      fire(4'h9, 3'h5, 24'habcdef);
      check(16'(lam_out), 16'h0000);
      check(16'(interval_enable_out), 16'h0001);
      rd(SUB_REG_THREE, r3(1, 1, 0, 0, 1));
      rd(SUB_REG_THREE, r3(1, 1, 0, 0, 1));
   endtask

   task automatic t_mask_cmds();
      logic [15:0] d;
      ctl(FUNC_ENA_LAM, SUB_CONTROL, 1'b1);
      run(FUNC_TEST_LAM, SUB_BOARD, 1'b1, d);
      check(16'(d[0]), 16'h0001);
      rd(SUB_REG_THREE, r3(1, 1, 0, 1, 1));
      ctl(FUNC_DIS_LAM, SUB_CONTROL, 1'b0);
      run(FUNC_TEST_LAM, SUB_BOARD, 1'b1, d);
      check(16'(d[0]), 16'h0000);
      ctl(FUNC_ENA_LAM, SUB_CONTROL, 1'b1);
   endtask

   // Register one of each event is read before the next event arrives.
   task automatic t_reads_clear();
      rd(SUB_REG_ONE, 16'h95ab);
      check(16'(lam_out), 16'h0000);
      rd(SUB_REG_THREE, r3(1, 1, 0, 1, 0));
      fire(4'hf, 3'h7, 24'h123456);
      check(16'(lam_out), 16'h0001);
      rd(SUB_REG_TWO, 16'h3456);
      check(16'(lam_out), 16'h0000);
      rd(SUB_REG_ONE, 16'hf712);
   endtask

   task automatic t_clear_cmd();
      fire(4'h1, 3'h1, 24'h000001);
      ctl(FUNC_CLR_LAM, SUB_CONTROL, 1'b0);
      rd(SUB_REG_THREE, r3(1, 1, 0, 1, 0));
   endtask

   task automatic t_unknown();
      logic [15:0] d;
      fire(4'h2, 3'h2, 24'h000002);
      foreach (BAD[i])
      begin
         run(BAD[i][8:4], BAD[i][3:0], 1'b0, d);
         check(d, 16'h0000);
      end
      check(16'(lam_out), 16'h0001);
      rd(SUB_REG_THREE, r3(1, 1, 0, 1, 1));
   endtask

   task automatic t_reset_cmd();
      ctl(FUNC_RESET, SUB_BOARD, 1'b0);
      rd(SUB_REG_THREE, r3(0, 1, 0, 0, 0));
      check(16'(interval_enable_out), 16'h0000);
   endtask

   task automatic t_reset_init();
      fire(4'h3, 3'h3, 24'h000003);
      ctl(FUNC_ENA_LAM, SUB_CONTROL, 1'b1);
      i_dataway_controller_model.init_pulse();
      check(16'(lam_out), 16'h0000);
      rd(SUB_REG_THREE, r3(0, 1, 0, 0, 0));
   endtask

   task automatic t_straps();
      for (int c = 0; c < 4; c++)
      begin
         @(posedge clk_in);
         {freq_strap_high_in, freq_strap_low_in} <= 2'(c);
         repeat (10) @(posedge clk_in);
         check(16'(freq_select_out), 16'(c));
         rd(SUB_REG_THREE, r3(0, c[1], c[0], 0, 0));
      end
   endtask

   initial
   begin
      repeat (10) @(posedge clk_in);
      rst_b_in <= 1'b1;
      @(posedge clk_in);
      t_idle();
      t_masked_event();
      t_mask_cmds();
      t_reads_clear();
      t_clear_cmd();
      t_unknown();
      t_reset_cmd();
      t_reset_init();
      t_straps();
      wrap_up();
   end
endmodule // test_camac_status_lam_interface
